// ---- pkg/tes_pkg.sv ----
/*
 Constants for the trigger exposure sequencer: register offsets, fields,
 reset values and timing counts.
 Assumes a 10 MHz system clock and a plain word register port.
*/
package tes_pkg;
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_INTEG = 8'h04;
    localparam logic [7:0] ADDR_READOUT = 8'h08;
    localparam logic [7:0] ADDR_ROWLEN = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_SWTRIG = 8'h14;
    // Control fields
    localparam int CTRL_TRIG_MODE_BIT = 0;
    localparam int CTRL_EDGE_POL_BIT = 1;
    // Status fields
    localparam int ST_EXPOSE_BIT = 0;
    localparam int ST_READOUT_BIT = 1;
    localparam int ST_ACCEPT_BIT = 2;
    localparam int ST_IDLE_BIT = 3;
    localparam int ST_IMAGING_BIT = 4;
    localparam int ST_MISSED_BIT = 5;
    // Reset values, in clock cycles where a time
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam logic [23:0] INTEG_RESET = 24'h0003E8;
    localparam logic [23:0] READOUT_RESET = 24'h002710;
    localparam logic [23:0] ROWLEN_RESET = 24'h000064;
    localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
endpackage

// ---- verilog/tes_sequencer.sv ----
/*
 Trigger exposure sequencer: turns trigger events into exposure and readout
 phases, overlapping a new exposure with the running readout.
 Assumes one 10 MHz clock, an asynchronous trigger pin, and a register
 master that keeps strobes one cycle long and never both at once.
*/
// Notes on behaviour
// - Readout starts by itself the moment an exposure ends.
// - An overlapped exposure ends only after the running readout has completed.
// - During readout, exposures start only on a row-gap boundary.
// - Lead delay equals readout length minus stored integration time, floored at zero.
// - Accept rises one lead delay after an exposure starts, but not before that exposure ends.
// - Accept shows whether another trigger would be taken now.
// - Exposure output is high exactly while integrating.
// - Readout output is high exactly while reading out.
// - Imaging is high while exposure or readout is active.
// - Idle is high while neither exposure nor readout is active.
// - Each exposure is timed with the integration time held in the register, or with the remaining readout when that is longer.
// - A trigger during readout may wait up to one row time.
// - In trigger mode no frame starts without a trigger event.
`timescale 1ns/1ps
module tes_sequencer #(
    parameter int TIME_W = 24
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Trigger pin
    input wire logic user_trigger,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Sequence indications
    output logic exposure_out,
    output logic readout_out,
    output logic trigger_accept,
    output logic imaging_out,
    output logic idle_out
);
    typedef enum logic [2:0] {
        TES_EXP_IDLE = 3'b001,
        TES_EXP_WAIT = 3'b010,
        TES_EXP_RUN = 3'b100
    } tes_exp_e;

    tes_exp_e exp_state_reg;
    logic [1:0] ctrl_reg;
    logic [TIME_W-1:0] integ_reg;
    logic [TIME_W-1:0] readout_len_reg;
    logic [TIME_W-1:0] row_len_reg;
    logic [2:0] trig_sync_reg;
    logic trig_level_reg;
    logic sw_trig_reg;
    logic missed_reg;
    logic [TIME_W-1:0] exp_cnt_reg;
    logic [TIME_W-1:0] exp_len_reg;
    logic [TIME_W-1:0] ro_cnt_reg;
    logic [TIME_W-1:0] row_cnt_reg;
    logic [TIME_W-1:0] lead_cnt_reg;
    logic lead_run_reg;
    logic ro_active_reg;
    logic accept_reg;
    logic exposure_reg;
    logic [31:0] rdata_reg;

    logic trig_edge;
    logic trig_event;
    logic row_gap;
    logic exp_start;
    logic exp_end;
    logic ro_end;
    logic [TIME_W-1:0] lead_delay;
    logic [TIME_W-1:0] ro_left;

    // Saturating difference, floored at zero
    function automatic logic [TIME_W-1:0] sat_sub(input logic [TIME_W-1:0] a,
                                                  input logic [TIME_W-1:0] b);
        sat_sub = (a > b) ? a - b : '0;
    endfunction

    // Trigger pin: three stages, change taken when stages two and three agree
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            trig_sync_reg <= 3'h0;
            trig_level_reg <= 1'b0;
        end else begin
            trig_sync_reg <= {trig_sync_reg[1:0], user_trigger};
            if (trig_sync_reg[1] == trig_sync_reg[2]) begin
                trig_level_reg <= trig_sync_reg[2];
            end
        end
    end

    assign trig_edge = (trig_sync_reg[1] == trig_sync_reg[2])
                       && (trig_sync_reg[2] != trig_level_reg)
                       && (trig_sync_reg[2] != ctrl_reg[tes_pkg::CTRL_EDGE_POL_BIT]);
    assign trig_event = ctrl_reg[tes_pkg::CTRL_TRIG_MODE_BIT] ? (trig_edge || sw_trig_reg)
                                                               : accept_reg;
    assign lead_delay = sat_sub(readout_len_reg, integ_reg);
    assign ro_left = sat_sub(readout_len_reg, ro_cnt_reg);
    assign row_gap = !ro_active_reg || (row_cnt_reg == '0);
    assign exp_end = (exp_state_reg == TES_EXP_RUN) && (exp_cnt_reg + 1'b1 >= exp_len_reg);
    assign ro_end = ro_active_reg && (ro_cnt_reg + 1'b1 >= readout_len_reg);
    assign exp_start = (exp_state_reg == TES_EXP_WAIT) && row_gap;

    // Registers written by software
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= tes_pkg::CTRL_RESET;
            integ_reg <= TIME_W'(tes_pkg::INTEG_RESET);
            readout_len_reg <= TIME_W'(tes_pkg::READOUT_RESET);
            row_len_reg <= TIME_W'(tes_pkg::ROWLEN_RESET);
            sw_trig_reg <= 1'b0;
        end else begin
            sw_trig_reg <= 1'b0;
            if (reg_wr) begin
                case (reg_addr)
                    tes_pkg::ADDR_CTRL: ctrl_reg <= reg_wdata[1:0];
                    tes_pkg::ADDR_INTEG: integ_reg <= (reg_wdata[TIME_W-1:0] == '0)
                                                      ? TIME_W'(1) : reg_wdata[TIME_W-1:0];
                    tes_pkg::ADDR_READOUT: readout_len_reg <= (reg_wdata[TIME_W-1:0] == '0)
                                                      ? TIME_W'(1) : reg_wdata[TIME_W-1:0];
                    tes_pkg::ADDR_ROWLEN: row_len_reg <= (reg_wdata[TIME_W-1:0] == '0)
                                                      ? TIME_W'(1) : reg_wdata[TIME_W-1:0];
                    tes_pkg::ADDR_SWTRIG: sw_trig_reg <= reg_wdata[0];
                    default: sw_trig_reg <= 1'b0;
                endcase
            end
        end
    end

    // Exposure state machine
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            exp_state_reg <= TES_EXP_IDLE;
            exp_cnt_reg <= '0;
            exp_len_reg <= '0;
            exposure_reg <= 1'b0;
        end else begin
            case (exp_state_reg)
                TES_EXP_IDLE: begin
                    if (trig_event && accept_reg) begin
                        exp_state_reg <= TES_EXP_WAIT;
                    end
                end
                TES_EXP_WAIT: begin
                    if (exp_start) begin
                        exp_state_reg <= TES_EXP_RUN;
                        exp_cnt_reg <= '0;
                        // Stretch so the exposure cannot end before the readout
                        exp_len_reg <= (ro_active_reg && ro_left > integ_reg)
                                       ? ro_left : integ_reg;
                        exposure_reg <= 1'b1;
                    end
                end
                TES_EXP_RUN: begin
                    exp_cnt_reg <= exp_cnt_reg + 1'b1;
                    if (exp_end) begin
                        exp_state_reg <= TES_EXP_IDLE;
                        exposure_reg <= 1'b0;
                    end
                end
                default: begin
                    exp_state_reg <= TES_EXP_IDLE;
                    exposure_reg <= 1'b0;
                end
            endcase
        end
    end

    // Readout phase and row timing
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ro_active_reg <= 1'b0;
            ro_cnt_reg <= '0;
            row_cnt_reg <= '0;
        end else begin
            if (exp_end) begin
                ro_active_reg <= 1'b1;
                ro_cnt_reg <= '0;
                row_cnt_reg <= '0;
            end else if (ro_active_reg) begin
                ro_cnt_reg <= ro_cnt_reg + 1'b1;
                row_cnt_reg <= (row_cnt_reg + 1'b1 >= row_len_reg) ? '0
                                                                   : row_cnt_reg + 1'b1;
                if (ro_end) begin
                    ro_active_reg <= 1'b0;
                end
            end
        end
    end

    // Accept: low from trigger until one lead delay after exposure start, and not before exposure end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            accept_reg <= 1'b1;
            lead_run_reg <= 1'b0;
            lead_cnt_reg <= '0;
            missed_reg <= 1'b0;
        end else begin
            if (exp_state_reg == TES_EXP_IDLE && trig_event && accept_reg) begin
                accept_reg <= 1'b0;
            end else if (exp_start) begin
                lead_run_reg <= 1'b1;
                lead_cnt_reg <= '0;
            end else if (lead_run_reg) begin
                lead_cnt_reg <= lead_cnt_reg + 1'b1;
                // Never while exposing: the exposure machine only takes triggers when idle
                if (lead_cnt_reg + 1'b1 >= lead_delay
                    && (exp_state_reg == TES_EXP_IDLE || exp_end)) begin
                    lead_run_reg <= 1'b0;
                    accept_reg <= 1'b1;
                end
            end
            if (trig_edge && !accept_reg) begin
                missed_reg <= 1'b1;
            end else if (reg_rd && reg_addr == tes_pkg::ADDR_STATUS) begin
                missed_reg <= 1'b0;
            end
        end
    end

    // Read data, valid in the cycle after the read strobe only
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                tes_pkg::ADDR_CTRL: rdata_reg <= {30'h0, ctrl_reg};
                tes_pkg::ADDR_INTEG: rdata_reg <= 32'(integ_reg);
                tes_pkg::ADDR_READOUT: rdata_reg <= 32'(readout_len_reg);
                tes_pkg::ADDR_ROWLEN: rdata_reg <= 32'(row_len_reg);
                tes_pkg::ADDR_STATUS: rdata_reg <= {26'h0, missed_reg,
                                                    exposure_reg || ro_active_reg,
                                                    !(exposure_reg || ro_active_reg),
                                                    accept_reg, ro_active_reg, exposure_reg};
                default: rdata_reg <= tes_pkg::UNMAPPED_DATA;
            endcase
        end else begin
            rdata_reg <= 32'h00000000;
        end
    end

    // Indication outputs, each from its own flip-flop
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            exposure_out <= 1'b0;
            readout_out <= 1'b0;
            trigger_accept <= 1'b0;
            imaging_out <= 1'b0;
            idle_out <= 1'b1;
        end else begin
            exposure_out <= exposure_reg;
            readout_out <= ro_active_reg;
            trigger_accept <= accept_reg;
            imaging_out <= exposure_reg || ro_active_reg;
            idle_out <= !(exposure_reg || ro_active_reg);
        end
    end

    assign reg_rdata = rdata_reg;
endmodule

// ---- verification/tes_trig_src.sv ----
/*
 Trigger source model: drives the user trigger pin with clean pulses.
 Assumes the bench calls pulse() and keeps pulses apart.
*/
`timescale 1ns/1ps
module tes_trig_src #(
    parameter int LATENCY = 4
) (
    // Clock and pin
    input wire logic sys_clk,
    output logic user_trigger
);
    initial user_trigger = 1'h0;
    // Pulse never shorter than three trigger latencies
    task automatic pulse(input int width);
        @(posedge sys_clk);
        user_trigger <= 1'h1;
        repeat ((width < 3 * LATENCY) ? 3 * LATENCY : width) @(posedge sys_clk);
        user_trigger <= 1'h0;
    endtask
endmodule

// ---- verification/tes_sequencer_chk.sv ----
/*
 Checker for the sequencer indications.
 Assumes it is bound to tes_sequencer and sees only its ports.
*/
`timescale 1ns/1ps
module tes_sequencer_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Indications
    input wire logic exposure_out,
    input wire logic readout_out,
    input wire logic trigger_accept,
    input wire logic imaging_out,
    input wire logic idle_out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    property p_imaging; imaging_out == (exposure_out || readout_out); endproperty
    property p_idle; idle_out == !(exposure_out || readout_out); endproperty
    property p_ro_start; $fell(exposure_out) |-> readout_out; endproperty
    property p_ro_cause; $rose(readout_out) |-> $fell(exposure_out); endproperty
    property p_exp_idle; $fell(trigger_accept) && idle_out |-> ##1 $rose(exposure_out); endproperty
    property p_exp_bound; $fell(trigger_accept) |-> ##[1:1000] exposure_out; endproperty
    property p_exp_gated; $rose(exposure_out) |-> !$past(trigger_accept); endproperty
    property p_acc_hold; $fell(trigger_accept) |-> !trigger_accept [*2]; endproperty
    a_imaging: assert property (p_imaging) else $error("imaging wrong");
    a_idle: assert property (p_idle) else $error("idle wrong");
    a_ro_start: assert property (p_ro_start) else $error("no readout");
    a_ro_cause: assert property (p_ro_cause) else $error("stray readout");
    a_exp_idle: assert property (p_exp_idle) else $error("slow start");
    a_exp_bound: assert property (p_exp_bound) else $error("no exposure");
    a_exp_gated: assert property (p_exp_gated) else $error("untriggered");
    a_acc_hold: assert property (p_acc_hold) else $error("accept back");
    c_frame: cover property ($rose(exposure_out));
    c_overlap: cover property (exposure_out && readout_out);
    c_busy_trig: cover property ($fell(trigger_accept) && readout_out);
endmodule
bind tes_sequencer tes_sequencer_chk u_tes_sequencer_chk (.sys_clk(sys_clk), .resetn(resetn),
    .exposure_out(exposure_out), .readout_out(readout_out), .trigger_accept(trigger_accept),
    .imaging_out(imaging_out), .idle_out(idle_out));

// ---- verification/test_trigger_exposure_sequencer.sv ----
/*
 Testbench for the trigger exposure sequencer.
 Assumes the trigger source model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module test_trigger_exposure_sequencer;
    logic sys_clk, resetn, reg_wr, reg_rd, user_trigger;
    logic exposure_out, readout_out, trigger_accept, imaging_out, idle_out;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    tes_sequencer u_tes_sequencer (.sys_clk(sys_clk), .resetn(resetn),
        .user_trigger(user_trigger), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exposure_out(exposure_out),
        .readout_out(readout_out), .trigger_accept(trigger_accept),
        .imaging_out(imaging_out), .idle_out(idle_out));
    tes_trig_src u_tes_trig_src (.sys_clk(sys_clk), .user_trigger(user_trigger));
    initial begin
        sys_clk = 1'h0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            test_done();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        @(negedge sys_clk);
        `CHK(nm, e, reg_rdata)
    endtask
    task automatic wait_hi(ref logic s);
        int k;
        k = 0;
        while (s !== 1'h1 && k < 500) begin
            @(negedge sys_clk);
            k++;
        end
    endtask
    task automatic fire();
        fork
            u_tes_trig_src.pulse(12);
        join_none
    endtask
    task automatic t_reset();
        rd(tes_pkg::ADDR_CTRL, 32'h1, "ctrl");
        rd(tes_pkg::ADDR_INTEG, 32'h3E8, "integ");
        rd(tes_pkg::ADDR_READOUT, 32'h2710, "readout");
        rd(tes_pkg::ADDR_ROWLEN, 32'h64, "rowlen");
        wr(8'h18, 32'hFFFFFFFF);
        rd(8'h18, 32'h0, "unmapped");
        rd(tes_pkg::ADDR_STATUS, 32'hC, "status");
        `CHK("no frame", 1'h0, exposure_out)
        $display("test reset done");
    endtask
    // Idle frame: integration 4, readout 20
    task automatic t_frame();
        int n, ne, na, nr;
        wr(tes_pkg::ADDR_INTEG, 32'h4);
        wr(tes_pkg::ADDR_READOUT, 32'h14);
        wr(tes_pkg::ADDR_ROWLEN, 32'h5);
        fire();
        wait_hi(exposure_out);
        {n, ne, na, nr} = '0;
        while (nr == 0 && n < 200) begin
            @(negedge sys_clk);
            n++;
            if (!exposure_out && ne == 0) ne = n;
            if (trigger_accept && na == 0) na = n;
            if (ne != 0 && !readout_out) nr = n;
        end
        `CHK("exposure length", 4, ne)
        `CHK("lead delay", 16, na)
        `CHK("readout end", 24, nr)
        $display("test frame done");
    endtask
    // Overlap: integration 20, readout 40, retrigger on accept, one early trigger
    task automatic t_overlap();
        int n, f, nf, nr;
        wr(tes_pkg::ADDR_INTEG, 32'h14);
        wr(tes_pkg::ADDR_READOUT, 32'h28);
        fire();
        wait_hi(exposure_out);
        {n, f, nf, nr} = '0;
        while (nr == 0 && n < 300) begin
            @(negedge sys_clk);
            n++;
            if (trigger_accept && f == 0) begin
                f = 1;
                fire();
            end
            if (exposure_out && f == 1 && n > 40) begin
                f = 2;
                fire();
            end
            if (!exposure_out && f == 2 && nf == 0) nf = n;
            if (!readout_out && nf != 0) nr = n;
        end
        `CHK("overlap exposure end", 61, nf)
        `CHK("readout run end", 101, nr)
        repeat (50) @(negedge sys_clk);
        `CHK("stays idle", 1'h1, idle_out)
        rd(tes_pkg::ADDR_STATUS, 32'h2C, "missed");
        rd(tes_pkg::ADDR_STATUS, 32'hC, "status");
        $display("test overlap done");
    endtask
    task automatic t_modes();
        wr(tes_pkg::ADDR_SWTRIG, 32'h1);
        wait_hi(exposure_out);
        `CHK("sw frame", 1'h1, exposure_out)
        wait_hi(idle_out);
        wr(tes_pkg::ADDR_CTRL, 32'h3);
        fire();
        repeat (10) @(negedge sys_clk);
        `CHK("no frame on rise", 1'h0, exposure_out)
        wait_hi(exposure_out);
        `CHK("frame on fall", 1'h1, exposure_out)
        wait_hi(idle_out);
        wr(tes_pkg::ADDR_CTRL, 32'h0);
        wait_hi(exposure_out);
        `CHK("free run frame", 1'h1, exposure_out)
        $display("test modes done");
    endtask
    initial begin
        resetn = 1'h0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'h1;
        t_reset();
        t_frame();
        t_overlap();
        t_modes();
        test_done();
    end
endmodule
